/* dsp_dma_channel_control.v */
// Notes on behaviour
// [RULE1] repeat 0: reinit only when programming done
// [RULE2] repeat 1: reinit regardless of programming flag
// [RULE3] no auto-init: channel stops after block
// [RULE4] auto-init: reinit and start next block
// [RULE5] enable low aborts and resets channel
// [RULE6] block completion clears enable; the code clears it only without auto-init, and auto-init leaves it set
// [RULE7] completion clear beats cpu write
// [RULE8] enabled channel eligible at next slot
// [RULE9] six chained channels, high urgency first
// [RULE10] element per event, or frame per event
// [RULE11] five-bit trigger select, zero unsynchronised
// [RULE12] codes map request lines, three unused
// [RULE13] block end flag and channel interrupt
// [RULE14] final frame start flag and interrupt
// [RULE15] frame complete flag and interrupt
// [RULE16] half frame flag and interrupt
// [RULE17] early trigger is drop, flagged if enabled
// [RULE18] time-out flag raises bus-error interrupt
// [RULE19] own interrupt line, flag same cycle
// [RULE20] no flag while its enable low
// [RULE21] sync status shows waiting trigger
// [RULE22] drop disables the channel
// [RULE23] auto-init with programming done reinitialises
// [RULE24] reinit copies programmed shape to working
// [RULE25] status read clears, debug read keeps
// [RULE26] same level: lowest channel first
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "dma_chan_consts.vh"

module dsp_dma_channel_control #(
  parameter NCH = `NUM_CHANNELS,
  parameter NRQ = `NUM_REQ_LINES
) (
  input  wire           CLK_I,          // dsp clock, 20 MHz
  input  wire           RSTN_I,         // async reset, active low
  input  wire           PSEL_I,         // apb select
  input  wire           PENABLE_I,      // apb access phase
  input  wire           PWRITE_I,       // apb direction
  input  wire [7:0]     PADDR_I,        // apb byte address
  input  wire [31:0]    PWDATA_I,       // apb write data
  output reg  [31:0]    PRDATA_O,       // apb read data
  output wire           PREADY_O,       // apb ready
  output wire           PSLVERR_O,      // apb error, unmapped address
  input  wire           DEBUG_READ_I,   // reads come from the debugger
  input  wire [NRQ:1]   DMA_REQ_I,      // peripheral request lines, async
  input  wire [NCH-1:0] TIMEOUT_I,      // port time-out pulse per channel
  output reg  [NCH-1:0] GRANT_O,        // element moved in the previous cycle
  output reg  [NCH-1:0] CH_IRQ_O,       // channel interrupt pulses
  output reg  [NCH-1:0] BUS_ERR_IRQ_O   // bus-error interrupt pulses
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg  [11:0]    ctrl       [0:NCH-1];
  reg  [5:0]     irq_en     [0:NCH-1];
  reg  [5:0]     flags      [0:NCH-1];
  reg  [15:0]    shape      [0:NCH-1];
  // working copies: the running block uses these while software reprograms
  reg  [7:0]     w_elems    [0:NCH-1];
  reg  [7:0]     w_frames   [0:NCH-1];
  reg  [4:0]     w_trig     [0:NCH-1];
  reg            w_fmode    [0:NCH-1];
  reg  [7:0]     ecnt       [0:NCH-1];
  reg  [7:0]     fcnt       [0:NCH-1];
  reg  [NCH-1:0] active;
  reg  [NCH-1:0] pending;
  reg  [NCH-1:0] frame_run;
  reg  [NCH-1:0] wait_reinit;
  reg  [NRQ:1]   req_meta;
  reg  [NRQ:1]   req_sync;
  reg  [NRQ:1]   req_prev;

  wire [NRQ:1]   req_edge;
  wire [NCH-1:0] gnt;
  wire [2:0]     sel_ch;
  wire [1:0]     sel_reg;
  wire           addr_ok;
  wire           wr_acc;
  wire           rd_acc;

  reg  [NCH-1:0] want;
  reg  [NCH-1:0] urgent;
  reg  [NCH-1:0] hit;
  reg  [NCH-1:0] half_ev;
  reg  [NCH-1:0] frame_ev;
  reg  [NCH-1:0] last_ev;
  reg  [NCH-1:0] block_ev;
  reg  [NCH-1:0] drop_ev;
  reg  [NCH-1:0] reinit;
  reg  [NCH-1:0] finish;
  reg  [NCH-1:0] wr_ctrl;
  reg  [NCH-1:0] wr_irqc;
  reg  [NCH-1:0] wr_shape;
  reg  [NCH-1:0] rd_clr;
  reg  [5:0]     sets       [0:NCH-1];

  integer i;
  integer j;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // [RULE12] unused codes and codes past the table never fire
  function trig_hit;
    input [4:0]   code;
    input [NRQ:1] lines;
    begin
      if (code == `TRIG_NONE || code == `TRIG_FREE_A || code == `TRIG_FREE_B ||
          code == `TRIG_FREE_C || code > `TRIG_LAST) begin
        trig_hit = 1'b0;
      end else begin
        trig_hit = lines[code];
      end
    end
  endfunction

  function [31:0] reg_view;
    input [2:0] ch;
    input [1:0] rsel;
    begin
      if (rsel == `OFS_CONTROL) begin
        reg_view = {20'h00000, ctrl[ch] & 12'hBFF};
      end else if (rsel == `OFS_IRQ_CONTROL) begin
        reg_view = {26'h0000000, irq_en[ch]};
      end else if (rsel == `OFS_STATUS) begin
        reg_view = {25'h0000000, pending[ch], flags[ch]};
      end else begin
        reg_view = {16'h0000, shape[ch]};
      end
    end
  endfunction

  // true when the access targets register rsel of channel ch
  function reg_pick;
    input [2:0] a_ch;
    input [1:0] a_reg;
    input [2:0] ch;
    input [1:0] rsel;
    begin
      reg_pick = (a_ch == ch) && (a_reg == rsel);
    end
  endfunction

  // ----------------------------------------
  // request line synchronisers
  // ----------------------------------------
  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      req_meta <= {NRQ{1'b0}};
      req_sync <= {NRQ{1'b0}};
      req_prev <= {NRQ{1'b0}};
    end else begin
      req_meta <= DMA_REQ_I;
      req_sync <= req_meta;
      req_prev <= req_sync;
    end
  end

  // the edge flop reads only the second stage; the first may be metastable
  assign req_edge = req_sync & ~req_prev;

  // ----------------------------------------
  // apb slave: zero wait states
  // ----------------------------------------
  assign sel_ch    = PADDR_I[6:4];
  assign sel_reg   = PADDR_I[3:2];
  assign addr_ok   = !PADDR_I[7] && (sel_ch < NCH) && (PADDR_I[1:0] == 2'b00);
  assign PREADY_O  = 1'b1;
  // unmapped accesses still finish at once; only the error flag tells
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~addr_ok;
  assign wr_acc    = PSEL_I & PENABLE_I & PWRITE_I & addr_ok;
  assign rd_acc    = PSEL_I & PENABLE_I & ~PWRITE_I & addr_ok;

  // read data is caught in the setup phase so it leaves a flop
  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      PRDATA_O <= 32'h00000000;
    end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
      if (addr_ok) begin
        PRDATA_O <= reg_view(sel_ch, sel_reg);
      end else begin
        PRDATA_O <= 32'h00000000;
      end
    end
  end

  // ----------------------------------------
  // arbiter
  // ----------------------------------------
  // one element moves per cycle across all channels
  service_picker #(
    .N (NCH)
  ) u_picker (
    .req_i    (want),
    .urgent_i (urgent),
    .gnt_o    (gnt)
  );

  // ----------------------------------------
  // per-channel event decode
  // ----------------------------------------
  always @* begin
    for (j = 0; j < NCH; j = j + 1) begin
      urgent[j]  = ctrl[j][`CC_URGENCY];
      // [RULE11] several channels may share one line
      hit[j]     = active[j] & ~wait_reinit[j] & trig_hit(w_trig[j], req_edge);
      // [RULE8] enabled and loaded channel asks for a slot
      want[j]    = active[j] & ctrl[j][`CC_ENABLE] & ~wait_reinit[j] &
                   ((w_trig[j] == `TRIG_NONE) | pending[j] | frame_run[j]);
      half_ev[j] = gnt[j] & (ecnt[j] + 8'h01 == {1'b0, w_elems[j][7:1]});
      frame_ev[j] = gnt[j] & (ecnt[j] + 8'h01 == w_elems[j]);
      last_ev[j] = gnt[j] & (ecnt[j] == 8'h00) & (fcnt[j] + 8'h01 == w_frames[j]);
      block_ev[j] = frame_ev[j] & (fcnt[j] + 8'h01 == w_frames[j]);
      // [RULE17] trigger while previous request unserved
      drop_ev[j] = hit[j] & ((pending[j] & ~gnt[j]) | (frame_run[j] & ~frame_ev[j]));
      // [RULE1] [RULE2] [RULE23] reinit gating
      reinit[j]  = ctrl[j][`CC_AUTO_INIT] &
                   (ctrl[j][`CC_REPEAT] | ctrl[j][`CC_PROG_DONE]) &
                   (block_ev[j] | wait_reinit[j]);
      // [RULE3] no auto-init: block end is final
      finish[j]  = block_ev[j] & ~ctrl[j][`CC_AUTO_INIT];
      wr_ctrl[j] = wr_acc & reg_pick(sel_ch, sel_reg, j[2:0], `OFS_CONTROL);
      wr_irqc[j] = wr_acc & reg_pick(sel_ch, sel_reg, j[2:0], `OFS_IRQ_CONTROL);
      wr_shape[j] = wr_acc & reg_pick(sel_ch, sel_reg, j[2:0], `OFS_SHAPE);
      // [RULE25] debugger reads leave flags alone
      rd_clr[j]  = rd_acc & ~DEBUG_READ_I & reg_pick(sel_ch, sel_reg, j[2:0], `OFS_STATUS);
      // [RULE20] every set is gated by its enable
      sets[j]    = irq_en[j] & {block_ev[j], last_ev[j], frame_ev[j], half_ev[j],
                                drop_ev[j], TIMEOUT_I[j] & active[j]};
    end
  end

  // ----------------------------------------
  // per-channel registers and sequencing
  // ----------------------------------------
  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      for (i = 0; i < NCH; i = i + 1) begin
        ctrl[i]     <= `CC_RESET;
        irq_en[i]   <= `IRQC_RESET;
        flags[i]    <= 6'h00;
        shape[i]    <= `SHAPE_RESET;
        w_elems[i]  <= 8'h01;
        w_frames[i] <= 8'h01;
        w_trig[i]   <= 5'h00;
        w_fmode[i]  <= 1'b0;
        ecnt[i]     <= 8'h00;
        fcnt[i]     <= 8'h00;
      end
      active        <= {NCH{1'b0}};
      pending       <= {NCH{1'b0}};
      frame_run     <= {NCH{1'b0}};
      wait_reinit   <= {NCH{1'b0}};
      GRANT_O       <= {NCH{1'b0}};
      CH_IRQ_O      <= {NCH{1'b0}};
      BUS_ERR_IRQ_O <= {NCH{1'b0}};
    end else begin
      // grant is reported from a flop, one cycle after the slot
      GRANT_O <= gnt;
      for (i = 0; i < NCH; i = i + 1) begin
        // [RULE19] flag and interrupt on the same edge
        CH_IRQ_O[i]      <= |sets[i][`EV_BLOCK:`EV_DROP];
        // [RULE18] time-out goes to the bus-error line
        BUS_ERR_IRQ_O[i] <= sets[i][`EV_TOUT];
        // [RULE13] [RULE14] [RULE15] [RULE16] set beats read clear
        // only bits the reader saw are cleared, so a flag set at the setup edge survives
        flags[i] <= (flags[i] & ~({6{rd_clr[i]}} & PRDATA_O[5:0])) | sets[i];

        if (wr_irqc[i]) begin
          irq_en[i] <= PWDATA_I[5:0];
        end
        if (wr_shape[i]) begin
          shape[i] <= PWDATA_I[15:0];
        end

        // control fields other than enable follow cpu writes
        if (wr_ctrl[i]) begin
          ctrl[i][11:8] <= PWDATA_I[11:8];
          ctrl[i][6:0]  <= PWDATA_I[6:0];
        end
        // [RULE6] [RULE7] [RULE22] hardware clear wins over cpu
        if (finish[i] || drop_ev[i]) begin
          ctrl[i][`CC_ENABLE] <= 1'b0;
        end else if (wr_ctrl[i]) begin
          ctrl[i][`CC_ENABLE] <= PWDATA_I[`CC_ENABLE];
        end

        // element and frame progress
        if (gnt[i]) begin
          if (frame_ev[i]) begin
            ecnt[i] <= 8'h00;
            fcnt[i] <= fcnt[i] + 8'h01;
          end else begin
            ecnt[i] <= ecnt[i] + 8'h01;
          end
        end

        // [RULE21] sync status tracks the waiting trigger
        if (hit[i] && !drop_ev[i]) begin
          pending[i] <= 1'b1;
        end else if (gnt[i]) begin
          pending[i] <= 1'b0;
        end
        // [RULE10] frame mode keeps requesting slots for the whole frame
        if (gnt[i] && pending[i] && w_fmode[i] && !frame_ev[i]) begin
          frame_run[i] <= 1'b1;
        end else if (frame_ev[i]) begin
          frame_run[i] <= 1'b0;
        end

        // parked until repeat or programming done allows the reload; enable stays set
        if (block_ev[i] && ctrl[i][`CC_AUTO_INIT] && !reinit[i]) begin
          wait_reinit[i] <= 1'b1;
        end

        // [RULE5] [RULE22] abort on disable or drop
        if (!ctrl[i][`CC_ENABLE] || drop_ev[i] || finish[i]) begin
          active[i]      <= 1'b0;
          pending[i]     <= 1'b0;
          frame_run[i]   <= 1'b0;
          wait_reinit[i] <= 1'b0;
          ecnt[i]        <= 8'h00;
          fcnt[i]        <= 8'h00;
        end else if (!active[i] || reinit[i]) begin
          // [RULE4] [RULE24] load working copy and start a block
          active[i]      <= 1'b1;
          wait_reinit[i] <= 1'b0;
          pending[i]     <= 1'b0;
          frame_run[i]   <= 1'b0;
          ecnt[i]        <= 8'h00;
          fcnt[i]        <= 8'h00;
          w_elems[i]     <= shape[i][`SH_ELEM_HI:`SH_ELEM_LO];
          w_frames[i]    <= shape[i][`SH_FRAME_HI:`SH_FRAME_LO];
          w_trig[i]      <= ctrl[i][`CC_TRIG_HI:`CC_TRIG_LO];
          w_fmode[i]     <= ctrl[i][`CC_FRAME_MODE];
        end
      end
    end
  end

endmodule // dsp_dma_channel_control

/* dma_chan_consts.vh */
`ifndef DMA_CHAN_CONSTS_VH
`define DMA_CHAN_CONSTS_VH

// ----------------------------------------
// register map (word indices inside one channel window)
// ----------------------------------------
`define CH_STRIDE_SHIFT     4
`define OFS_CONTROL         2'h0
`define OFS_IRQ_CONTROL     2'h1
`define OFS_STATUS          2'h2
`define OFS_SHAPE           2'h3
`define NUM_CHANNELS        6
`define NUM_REQ_LINES       19

// ----------------------------------------
// channel_control fields
// ----------------------------------------
`define CC_PROG_DONE        11
`define CC_REPEAT           9
`define CC_AUTO_INIT        8
`define CC_ENABLE           7
`define CC_URGENCY          6
`define CC_FRAME_MODE       5
`define CC_TRIG_HI          4
`define CC_TRIG_LO          0
`define CC_RESET            12'h000

// ----------------------------------------
// channel_irq_control and channel_status fields
// ----------------------------------------
`define EV_BLOCK            5
`define EV_LAST             4
`define EV_FRAME            3
`define EV_HALF             2
`define EV_DROP             1
`define EV_TOUT             0
`define ST_SYNC             6
`define IRQC_RESET          6'h03

// ----------------------------------------
// channel_shape fields
// ----------------------------------------
`define SH_ELEM_HI          7
`define SH_ELEM_LO          0
`define SH_FRAME_HI         15
`define SH_FRAME_LO         8
`define SHAPE_RESET         16'h0101

// ----------------------------------------
// trigger codes left unconnected, and the last mapped code
// ----------------------------------------
`define TRIG_NONE           5'h00
`define TRIG_FREE_A         5'h07
`define TRIG_FREE_B         5'h10
`define TRIG_FREE_C         5'h11
`define TRIG_LAST           5'h13

`endif

/* service_picker.v */
`timescale 1ns/1ps

// two-level fixed chain arbiter: urgent pool first, lowest index wins
module service_picker #(
  parameter N = 6
) (
  input  wire [N-1:0] req_i,     // channels wanting a slot
  input  wire [N-1:0] urgent_i,  // per-channel high level
  output wire [N-1:0] gnt_o      // one-hot grant
);

  wire [N-1:0] urgent_req;
  wire [N-1:0] pool;

  assign urgent_req = req_i & urgent_i;
  // [RULE9] high level served first
  assign pool       = (|urgent_req) ? urgent_req : req_i;
  // [RULE26] lowest index first
  assign gnt_o      = pool & (~pool + {{(N-1){1'b0}}, 1'b1});

endmodule // service_picker

/* dma_chan_sva.sv */
`timescale 1ns/1ps
module dma_chan_sva #(
  parameter NCH = 6
) (
  input wire logic           CLK_I,        // clock
  input wire logic           RSTN_I,       // reset, low
  input wire logic           PSEL_I,       // select
  input wire logic           PENABLE_I,    // access
  input wire logic           PWRITE_I,     // direction
  input wire logic [7:0]     PADDR_I,      // address
  input wire logic [31:0]    PWDATA_I,     // write data
  input wire logic [31:0]    PRDATA_O,     // read data
  input wire logic           PREADY_O,     // ready
  input wire logic           PSLVERR_O,    // error
  input wire logic [NCH-1:0] TIMEOUT_I,    // time-outs
  input wire logic [NCH-1:0] GRANT_O,      // grants
  input wire logic [NCH-1:0] BUS_ERR_IRQ_O // bus errors
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  // ----------------------------------------
  // sequences
  // ----------------------------------------
  sequence access_s;
    PSEL_I && PENABLE_I;
  endsequence
  sequence urgent_go_s;
    access_s ##0 PWRITE_I && PADDR_I == 8'h00 && PWDATA_I[7:6] == 2'h3 && PWDATA_I[4:0] == 5'h00;
  endsequence
  // ----------------------------------------
  // properties
  // ----------------------------------------
  start_slot_a: assert property (urgent_go_s |-> ##[2:5] GRANT_O[0])
    else $error("urgent channel not served");
  one_grant_a: assert property ($onehot0(GRANT_O))
    else $error("more than one grant");
  tout_cause_a: assert property ((BUS_ERR_IRQ_O & ~($past(TIMEOUT_I) | $past(TIMEOUT_I, 2))) == 0)
    else $error("bus error without time-out");
  ready_high_a: assert property (PREADY_O)
    else $error("ready low");
  bad_addr_a: assert property (access_s ##0 PADDR_I[7] |-> PSLVERR_O)
    else $error("unmapped access not flagged");
  good_addr_a: assert property (access_s ##0 !PADDR_I[7] && PADDR_I[6:4] < 3'h6
      && PADDR_I[1:0] == 2'h0 |-> !PSLVERR_O)
    else $error("mapped access flagged");
  bad_read_a: assert property (access_s ##0 !PWRITE_I && PADDR_I[7] |-> PRDATA_O == 32'h0)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!(PSEL_I && !PENABLE_I && !PWRITE_I) |=> $stable(PRDATA_O))
    else $error("read data moved");
endmodule // dma_chan_sva

/* dma_req_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// peripheral request and port time-out sources
// ----------------------------------------
module dma_req_model (
  input  wire logic        clk_i,  // clock
  output logic      [19:1] req_o,  // request lines
  output logic      [5:0]  tout_o  // time-out pulses
);
  initial req_o = '0;
  initial tout_o = '0;
  // held four cycles so the two-stage sync and edge flop surely see the edge
  task pulse_req(input int l);
    req_o[l] <= 1'b1;
    repeat (4) @(posedge clk_i);
    req_o[l] <= 1'b0;
    @(posedge clk_i);
  endtask
  task pulse_tout(input int c);
    tout_o[c] <= 1'b1;
    @(posedge clk_i);
    tout_o[c] <= 1'b0;
  endtask
endmodule // dma_req_model

/* dma_chan_tb.sv */
`timescale 1ns/1ps
module testbench;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwrite = 1'b0;
  logic        dbg = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [19:1] req;
  logic [5:0]  tout;
  logic [5:0]  gnt;
  logic [5:0]  irq;
  logic [5:0]  berr;
  logic [31:0] rv;
  logic        err;
  int          miscompares = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  int          k;
  int          gc[6];
  int          ic[6];
  int          bc[6];
  always #25 clk = ~clk;
  dsp_dma_channel_control i_dut (.CLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .DEBUG_READ_I(dbg), .DMA_REQ_I(req), .TIMEOUT_I(tout), .GRANT_O(gnt),
    .CH_IRQ_O(irq), .BUS_ERR_IRQ_O(berr));
  dma_req_model i_src (.clk_i(clk), .req_o(req), .tout_o(tout));
  always @(posedge clk) begin
    cycles++;
    for (int i = 0; i < 6; i++) begin
      gc[i] += gnt[i];
      ic[i] += irq[i];
      bc[i] += berr[i];
    end
    if (cycles == 5000) begin
      miscompares++;
      end_sim();
    end
  end
  task end_sim;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  // one transfer; request held until ready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rc(input string s, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    apb(1'b0, a, 32'h0);
    chk(s, e, rv & m);
  endtask
  task clr;
    @(negedge clk);
    gc = '{default:0};
    ic = '{default:0};
    bc = '{default:0};
    @(posedge clk);
  endtask
  task idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (int c = 0; c < 6; c++) begin
      rc("ctrl", 8'(c * 16), 32'h0);
      rc("irqc", 8'(c * 16 + 4), 32'h3);
      rc("shape", 8'(c * 16 + 12), 32'h0101);
    end
    wr(8'h50, 32'hFFF);
    rc("ctrl5", 8'h50, 32'hBFF);
    wr(8'h50, 32'h0);
    rc("hole", 8'h60, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    wr(8'h04, 32'h3F);
    clr;
    wr(8'h00, 32'h80);
    idle(10);
    chk("grants0", 1, gc[0]);
    chk("irqs0", 1, ic[0]);
    rc("ctrl0", 8'h00, 32'h0);
    rc("stat0", 8'h08, 32'h38);
    rc("stat0", 8'h08, 32'h0);
    wr(8'h14, 32'h0);
    clr;
    wr(8'h10, 32'h80);
    idle(10);
    chk("irqs1", 0, ic[1]);
    rc("stat1", 8'h18, 32'h0);
    wr(8'h24, 32'h04);
    wr(8'h2C, 32'h0104);
    wr(8'h20, 32'h80);
    idle(12);
    dbg <= 1'b1;
    rc("dbg", 8'h28, 32'h04);
    dbg <= 1'b0;
    rc("half", 8'h28, 32'h04);
    rc("clear", 8'h28, 32'h0);
    wr(8'h24, 32'h0);
    wr(8'h2C, 32'h0102);
    wr(8'h3C, 32'h0102);
    for (int c = 1; c < 20; c++) begin
      wr(8'h20, 32'hA0 | c);
      wr(8'h30, 32'h80 | c);
      clr;
      i_src.pulse_req(c);
      idle(10);
      k = (c == 7 || c == 16 || c == 17) ? 0 : 1;
      chk("frame", 2 * k, gc[2]);
      chk("elem", k, gc[3]);
      wr(8'h20, 32'h0);
      wr(8'h30, 32'h0);
    end
    // urgent channel 0 keeps the slot, so lower channels must wait
    wr(8'h0C, 32'h20FF);
    wr(8'h00, 32'hC0);
    wr(8'h4C, 32'h0102);
    wr(8'h40, 32'h89);
    wr(8'h50, 32'h80);
    clr;
    i_src.pulse_req(9);
    idle(4);
    rc("sync", 8'h48, 32'h40);
    i_src.pulse_req(9);
    idle(4);
    rc("dropen", 8'h40, 32'h09);
    rc("drop", 8'h48, 32'h02, 32'h3F);
    chk("low", 0, gc[5]);
    i_src.pulse_tout(0);
    idle(4);
    chk("berr", 1, bc[0]);
    rc("tout", 8'h08, 32'h01, 32'h01);
    clr;
    wr(8'h00, 32'h0);
    idle(10);
    chk("next", 1, gc[5]);
    clr;
    idle(5);
    chk("abort", 0, gc[0]);
    wr(8'h14, 32'h20);
    clr;
    wr(8'h10, 32'h380);
    idle(20);
    chk("repeat", 1, ic[1] >= 2);
    wr(8'h10, 32'h180);
    idle(10);
    clr;
    idle(20);
    chk("hold", 0, ic[1]);
    rc("wait", 8'h10, 32'h180);
    clr;
    wr(8'h10, 32'h980);
    idle(10);
    chk("prog", 1, ic[1] >= 1);
    wr(8'h10, 32'h080);
    idle(10);
    rc("stop", 8'h10, 32'h0);
    end_sim();
  end
endmodule // testbench
bind dsp_dma_channel_control dma_chan_sva #(.NCH(NCH)) i_sva (.CLK_I(CLK_I), .RSTN_I(RSTN_I),
  .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
  .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .TIMEOUT_I(TIMEOUT_I), .GRANT_O(GRANT_O), .BUS_ERR_IRQ_O(BUS_ERR_IRQ_O));
